// ### src/memory_protection_pkg.sv
// Purpose: Shared constants, encodings and carriers for the memory protection checker.
// Assumes: Register bus is 32 bits wide with byte addresses; regions hold 4-byte word addresses.
// Notes:   Offsets are byte addresses; every register is one aligned word.
`default_nettype none

package memory_protection_pkg;

    // ==========================================================================
    // Region geometry.
    localparam int unsigned REGION_COUNT = 8;
    localparam int unsigned CFG_BITS     = 8;
    localparam int unsigned CFGS_PER_REG = 4;
    localparam int unsigned ADDR_W_RV32  = 32;
    localparam int unsigned ADDR_W_RV64  = 54;
    localparam int unsigned ADDR_REG_MAX = 54;
    localparam int unsigned PHYS_MAX     = 56;
    localparam int unsigned WORD_SHIFT   = 2;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned BUS_ADDR_W   = 8;
    localparam int unsigned HI_W         = ADDR_REG_MAX - DATA_W;

    // ==========================================================================
    // Configuration field layout.
    localparam int unsigned CFG_R    = 0;
    localparam int unsigned CFG_W    = 1;
    localparam int unsigned CFG_X    = 2;
    localparam int unsigned CFG_A_LO = 3;
    localparam int unsigned CFG_A_HI = 4;
    localparam int unsigned CFG_L    = 7;
    localparam logic [7:0]  CFG_WRITE_MASK = 8'h9f;

    // Address matching modes, in field encoding order.
    typedef enum logic [1:0] {
        mode_off,
        top_of_range_mode,
        four_byte_mode,
        power_of_two_mode
    } match_mode_e;

    // ==========================================================================
    // Register offsets.
    localparam logic [7:0] REG_CFG_LO       = 8'h00;
    localparam logic [7:0] REG_CFG_HI       = 8'h04;
    localparam logic [7:0] REG_ADDR_LO_BASE = 8'h20;
    localparam logic [7:0] REG_ADDR_HI_BASE = 8'h40;
    localparam logic [7:0] REG_STATUS       = 8'h60;
    localparam logic [7:0] REG_CLEAR        = 8'h64;
    localparam logic [7:0] REG_ENABLE       = 8'h68;
    localparam logic [7:0] REG_FAULT_ADDR   = 8'h6c;
    localparam logic [7:0] REG_STRIDE       = 8'h04;

    // Event bit positions in status, clear and enable.
    localparam int unsigned EV_LOAD  = 0;
    localparam int unsigned EV_STORE = 1;
    localparam int unsigned EV_FETCH = 2;
    localparam int unsigned EV_W     = 3;

    // ==========================================================================
    // Access kinds and privilege levels; kind codes equal the event bit positions.
    typedef enum logic [1:0] {
        kind_load,
        kind_store,
        kind_fetch
    } access_kind_e;

    typedef enum logic {
        priv_user,
        priv_machine
    } priv_level_e;

    // Register bus request.
    typedef struct packed {
        logic                  write;
        logic                  read;
        logic [BUS_ADDR_W-1:0] addr;
        logic [DATA_W-1:0]     wdata;
    } reg_req_s;

    // Access check request from the pipeline.
    typedef struct packed {
        logic                valid;
        access_kind_e        kind;
        priv_level_e         priv;
        logic [PHYS_MAX-1:0] addr;
    } access_req_s;

    // Access check answer, one cycle after the request.
    typedef struct packed {
        logic            valid;
        logic            granted;
        logic [EV_W-1:0] fault;
    } access_resp_s;

endpackage

`default_nettype wire

// ### src/physical_memory_protection_unit.sv
// Purpose: Checks load, store and fetch addresses against eight programmable regions.
// Assumes: Requests come from logic on clk_i; privilege is machine or user only.
// Notes:   The answer to a check stands one cycle after the request.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Eight regions, each config and address.
// - Unlocked regions checked only for user accesses.
// - Locked regions enforced on every access.
// - Locked config and address ignore writes.
// - Addresses compared as four-byte words.
// - Failed check blocks, raises matching exception.
// - Config field holds read, write, execute, lock.
// - Config field selects range or power mode.
// - 32-bit core: address holds 34-bit bits.
// - 64-bit core: address holds 56-bit bits.
// - Range mode: previous address to own address.
// - Region zero range starts at zero.
// - Lowest zero bit gives size code.
// - Size is two to position plus three.
// - Base is bits above lowest zero.
// - Decisions depend on machine or user.
module physical_memory_protection_unit #(
    parameter bit core_is_64 = 1'b0
) (
    // Clock and reset.
    input  wire logic                                clk_i,
    input  wire logic                                reset_i,
    // Register bus.
    input  wire memory_protection_pkg::reg_req_s     reg_req_i,
    output logic [memory_protection_pkg::DATA_W-1:0] reg_rdata_o,
    // Access check port.
    input  wire memory_protection_pkg::access_req_s  access_req_i,
    output var memory_protection_pkg::access_resp_s  access_resp_o,
    // Interrupt.
    output logic                                     irq_o
);

    // ==========================================================================
    // Widths of the selected core variant.
    localparam int unsigned ADDR_W = core_is_64 ? memory_protection_pkg::ADDR_W_RV64
                                                : memory_protection_pkg::ADDR_W_RV32;
    localparam int unsigned AW = memory_protection_pkg::ADDR_REG_MAX;
    localparam int unsigned NR = memory_protection_pkg::REGION_COUNT;
    localparam int unsigned CB = memory_protection_pkg::CFG_BITS;
    localparam int unsigned DW = memory_protection_pkg::DATA_W;
    localparam int unsigned EW = memory_protection_pkg::EV_W;
    // Config fields per register word, and the top field of the low word.
    localparam int unsigned CFGS        = memory_protection_pkg::CFGS_PER_REG;
    localparam int unsigned CFGS_LO_TOP = CFGS - 1;
    localparam logic [AW-1:0] WORD_MASK = AW'((65'h1 << ADDR_W) - 65'h1);

    // All state of the checker.
    typedef struct packed {
        logic [NR-1:0][CB-1:0] cfg;
        logic [NR-1:0][AW-1:0] addr;
        logic [EW-1:0]         status;
        logic [EW-1:0]         enable;
        logic [DW-1:0]         fault_addr;
        logic [DW-1:0]         rdata;
        memory_protection_pkg::access_resp_s resp;
    } state_s;

    state_s st;
    state_s next_st;

    logic [AW-1:0]      req_word;
    logic [NR-1:0]      hit;
    logic [NR-1:0]      cfg_locked;
    logic [NR-1:0]      addr_locked;
    logic [NR*CB-1:0]   cfg_lock_mask;
    logic [NR*AW-1:0]   addr_lock_mask;
    logic               sel_hit;
    logic               sel_locked;
    logic               sel_perm;
    logic               unmapped_read;

    // ==========================================================================
    // Request address as a word number, bits beyond the physical range dropped.
    assign req_word = access_req_i.addr[memory_protection_pkg::PHYS_MAX-1:
                                        memory_protection_pkg::WORD_SHIFT] & WORD_MASK;

    // ==========================================================================
    // Per-region match and lock evaluation, one copy for each region.
    for (genvar i = 0; i < NR; i++)
    begin : g_region
        logic [AW-1:0] lower;
        logic [AW-1:0] napot_mask;
        memory_protection_pkg::match_mode_e mode;

        // Mode selector taken from the config field.
        assign mode = memory_protection_pkg::match_mode_e'(
            st.cfg[i][memory_protection_pkg::CFG_A_HI:memory_protection_pkg::CFG_A_LO]);

        // Lower bound of a range region is the previous address, or zero for region 0.
        if (i == 0)
        begin : g_first
            assign lower = '0;
        end
        else
        begin : g_rest
            assign lower = st.addr[i-1];
        end

        // Trailing ones plus the lowest zero form the ignored low bits.
        assign napot_mask = st.addr[i] ^ (st.addr[i] + AW'(1));

        // Region hit under its selected mode.
        always_comb
        begin
            unique case (mode)
                memory_protection_pkg::top_of_range_mode:
                    hit[i] = (req_word >= lower) && (req_word < st.addr[i]);
                memory_protection_pkg::four_byte_mode:
                    hit[i] = (req_word == st.addr[i]);
                memory_protection_pkg::power_of_two_mode:
                    hit[i] = ((req_word | napot_mask) == (st.addr[i] | napot_mask));
                default:
                    hit[i] = 1'b0;
            endcase
        end

        // A locked field freezes itself, and a locked range above freezes its floor.
        assign cfg_locked[i] = st.cfg[i][memory_protection_pkg::CFG_L];
        if (i < NR - 1)
        begin : g_floor
            assign addr_locked[i] = cfg_locked[i] || (cfg_locked[i+1] &&
                (st.cfg[i+1][memory_protection_pkg::CFG_A_HI:memory_protection_pkg::CFG_A_LO]
                 == memory_protection_pkg::top_of_range_mode));
        end
        else
        begin : g_top
            assign addr_locked[i] = cfg_locked[i];
        end

        // Masks that show which state bits a lock freezes.
        assign cfg_lock_mask[i*CB +: CB]  = {CB{cfg_locked[i]}};
        assign addr_lock_mask[i*AW +: AW] = {AW{addr_locked[i]}};
    end

    // ==========================================================================
    // Next-state logic: register bus, access decision and event flags.
    always_comb
    begin
        logic              granted;
        logic [EW-1:0]     fault;
        logic [DW-1:0]     rd;
        logic [7:0]        lo_off;
        logic [7:0]        hi_off;
        next_st    = st;
        granted    = (access_req_i.priv == memory_protection_pkg::priv_machine);
        fault      = '0;
        rd         = '0;
        lo_off     = '0;
        hi_off     = '0;
        sel_hit    = 1'b0;
        sel_locked = 1'b0;
        sel_perm   = 1'b0;
        unmapped_read = reg_req_i.read;

        // Fixed registers: read data.
        unique case (reg_req_i.addr)
            memory_protection_pkg::REG_CFG_LO:
            begin
                rd = st.cfg[CFGS_LO_TOP:0];
                unmapped_read = 1'b0;
            end
            memory_protection_pkg::REG_CFG_HI:
            begin
                rd = st.cfg[NR-1:memory_protection_pkg::CFGS_PER_REG];
                unmapped_read = 1'b0;
            end
            memory_protection_pkg::REG_STATUS:
            begin
                rd = DW'(st.status);
                unmapped_read = 1'b0;
            end
            memory_protection_pkg::REG_ENABLE:
            begin
                rd = DW'(st.enable);
                unmapped_read = 1'b0;
            end
            memory_protection_pkg::REG_FAULT_ADDR:
            begin
                rd = st.fault_addr;
                unmapped_read = 1'b0;
            end
            default:
            begin
                rd = '0;
            end
        endcase

        // Config writes land per byte, skipping locked fields.
        for (int b = 0; b < NR; b++)
        begin
            if (reg_req_i.write && !cfg_locked[b] &&
                reg_req_i.addr == ((b < CFGS) ? memory_protection_pkg::REG_CFG_LO
                                              : memory_protection_pkg::REG_CFG_HI))
            begin
                next_st.cfg[b] = reg_req_i.wdata[(b % CFGS)*CB +: CB] &
                                 memory_protection_pkg::CFG_WRITE_MASK;
            end
        end

        // Address registers: one word each, high part only on the wide core.
        for (int r = 0; r < NR; r++)
        begin
            lo_off = 8'(memory_protection_pkg::REG_ADDR_LO_BASE
                        + r * memory_protection_pkg::REG_STRIDE);
            hi_off = 8'(memory_protection_pkg::REG_ADDR_HI_BASE
                        + r * memory_protection_pkg::REG_STRIDE);
            if (reg_req_i.addr == lo_off)
            begin
                rd = st.addr[r][DW-1:0];
                unmapped_read = 1'b0;
            end
            if (core_is_64 && reg_req_i.addr == hi_off)
            begin
                rd = DW'(st.addr[r][AW-1:DW]);
                unmapped_read = 1'b0;
            end
            if (reg_req_i.write && !addr_locked[r] && reg_req_i.addr == lo_off)
            begin
                next_st.addr[r][DW-1:0] = reg_req_i.wdata;
            end
            if (core_is_64 && reg_req_i.write && !addr_locked[r] && reg_req_i.addr == hi_off)
            begin
                next_st.addr[r][AW-1:DW] =
                    reg_req_i.wdata[memory_protection_pkg::HI_W-1:0];
            end
        end

        // Read data stand only in the cycle after the read strobe.
        next_st.rdata = reg_req_i.read ? rd : '0;

        // Enable and clear of the event flags.
        if (reg_req_i.write && reg_req_i.addr == memory_protection_pkg::REG_ENABLE)
        begin
            next_st.enable = reg_req_i.wdata[EW-1:0];
        end
        if (reg_req_i.write && reg_req_i.addr == memory_protection_pkg::REG_CLEAR)
        begin
            next_st.status = st.status & ~reg_req_i.wdata[EW-1:0];
        end

        // Lowest-numbered hit decides, so scan from the top down.
        for (int k = NR - 1; k >= 0; k--)
        begin
            if (hit[k])
            begin
                sel_hit    = 1'b1;
                sel_locked = cfg_locked[k];
                sel_perm   = st.cfg[k][access_req_i.kind];
            end
        end
        if (sel_hit)
        begin
            // Machine accesses skip unlocked regions; locked ones bind everyone.
            if (sel_locked || access_req_i.priv == memory_protection_pkg::priv_user)
            begin
                granted = sel_perm;
            end
            else
            begin
                granted = 1'b1;
            end
        end

        // Answer the check and raise the exception of the access kind.
        next_st.resp = '0;
        if (access_req_i.valid)
        begin
            fault[access_req_i.kind] = !granted;
            next_st.resp.valid   = 1'b1;
            next_st.resp.granted = granted;
            next_st.resp.fault   = fault;
            next_st.status       = next_st.status | fault; // Set wins over clear.
            if (!granted)
            begin
                next_st.fault_addr = access_req_i.addr[DW-1:0];
            end
        end
    end

    // ==========================================================================
    // State register; reset clears every region and its lock.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs.
    assign reg_rdata_o   = st.rdata;
    assign access_resp_o = st.resp;
    assign irq_o         = |(st.status & st.enable);

    // ==========================================================================
    // Checks on the decision path and the register file.
    a_lock_keeps_cfg: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> ((st.cfg & $past(cfg_lock_mask)) == ($past(st.cfg) & $past(cfg_lock_mask))))
        else $error("Locked config field changed.");

    a_lock_keeps_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> ((st.addr & $past(addr_lock_mask)) == ($past(st.addr) & $past(addr_lock_mask))))
        else $error("Locked address register changed.");

    a_machine_bypass: assert property (@(posedge clk_i) disable iff (reset_i)
        access_req_i.valid && access_req_i.priv == memory_protection_pkg::priv_machine &&
        !(sel_hit && sel_locked) |=> access_resp_o.valid && access_resp_o.granted)
        else $error("Machine access blocked by unlocked region.");

    a_locked_enforce: assert property (@(posedge clk_i) disable iff (reset_i)
        access_req_i.valid && sel_hit && sel_locked && !sel_perm |=> !access_resp_o.granted)
        else $error("Locked region did not block access.");

    a_user_unmatched: assert property (@(posedge clk_i) disable iff (reset_i)
        access_req_i.valid && access_req_i.priv == memory_protection_pkg::priv_user && !sel_hit
        |=> !access_resp_o.granted && access_resp_o.fault != '0)
        else $error("Unmatched user access was granted.");

    a_fault_kind: assert property (@(posedge clk_i) disable iff (reset_i)
        access_resp_o.valid && !access_resp_o.granted
        |-> access_resp_o.fault == (EW'(1) << $past(access_req_i.kind)))
        else $error("Exception kind does not match access.");

    a_status_sets: assert property (@(posedge clk_i) disable iff (reset_i)
        access_resp_o.fault != '0 |-> (st.status & access_resp_o.fault) == access_resp_o.fault)
        else $error("Fault did not set its status flag.");

    a_region0_floor: assert property (@(posedge clk_i) disable iff (reset_i)
        st.cfg[0][memory_protection_pkg::CFG_A_HI:memory_protection_pkg::CFG_A_LO] ==
        memory_protection_pkg::top_of_range_mode && req_word < st.addr[0] |-> hit[0])
        else $error("Region zero range does not start at zero.");

    a_read_unmapped: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_req_i.read && unmapped_read
        |=> reg_rdata_o == '0 ##1 (reg_rdata_o == '0 || $past(reg_req_i.read)))
        else $error("Unmapped read returned data.");

    // Status flags only fall through a write to the clear register.
    a_status_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
        !(reg_req_i.write && reg_req_i.addr == memory_protection_pkg::REG_CLEAR)
        |=> (st.status & $past(st.status)) == $past(st.status))
        else $error("Status flag fell without a clear.");

    // No answer comes without a check in the cycle before.
    a_resp_one_shot: assert property (@(posedge clk_i) disable iff (reset_i)
        access_req_i.valid == 1'b0 |=> !access_resp_o.valid)
        else $error("Answer without a request.");

    // A granted access raises no exception.
    a_grant_no_fault: assert property (@(posedge clk_i) disable iff (reset_i)
        access_resp_o.granted |-> access_resp_o.fault == '0)
        else $error("Granted access raised an exception.");

    // A denied access leaves its address for the exception handler.
    a_deny_logs_addr: assert property (@(posedge clk_i) disable iff (reset_i)
        access_resp_o.valid && !access_resp_o.granted
        |-> st.fault_addr == $past(access_req_i.addr[DW-1:0]))
        else $error("Denied access address not recorded.");

endmodule // physical_memory_protection_unit

`default_nettype wire

// ### bench/pipeline_model.sv
// Purpose: Behavioural pipeline that issues loads, stores and fetches to the checker.
// Assumes: One request at a time, launched just after a rising edge of clk_i.
// Notes:   The address is inverted when idle so a stale value is never mistaken for a request.
`timescale 1ns/1ps
`default_nettype none

module pipeline_model (
    // Clock.
    input  wire logic                                 clk_i,
    // Check request and answer.
    output var memory_protection_pkg::access_req_s    req_o,
    input  wire memory_protection_pkg::access_resp_s  resp_i
);
    // ==========================================================================
    // Request driver.
    // Holds the request for exactly one edge, then collects the answer of the next cycle.
    task automatic issue(input memory_protection_pkg::access_kind_e kind,
                         input memory_protection_pkg::priv_level_e  priv,
                         input logic [memory_protection_pkg::PHYS_MAX-1:0] addr,
                         output memory_protection_pkg::access_resp_s resp);
        @(posedge clk_i);
        req_o <= '{valid: 1'b1, kind: kind, priv: priv, addr: addr};
        @(posedge clk_i);
        req_o <= '{valid: 1'b0, kind: kind, priv: priv, addr: ~addr};
        #1;
        resp = resp_i;
    endtask

    // Idle at time zero.
    initial req_o = '0;
endmodule // pipeline_model

`default_nettype wire

// ### bench/test_physical_memory_protection_unit.sv
// Purpose: Self-checking bench for the memory protection checker.
// Assumes: 32-bit core variant; register writes act one cycle after they are taken.
// Notes:   Region layout: 0 range read-only, 1 power-of-two execute, 2 power-of-two full.
`timescale 1ns/1ps
`default_nettype none

module test_physical_memory_protection_unit;
    localparam memory_protection_pkg::access_kind_e ld = memory_protection_pkg::kind_load;
    localparam memory_protection_pkg::access_kind_e st = memory_protection_pkg::kind_store;
    localparam memory_protection_pkg::access_kind_e fe = memory_protection_pkg::kind_fetch;
    localparam memory_protection_pkg::priv_level_e  usr = memory_protection_pkg::priv_user;
    localparam memory_protection_pkg::priv_level_e  mch = memory_protection_pkg::priv_machine;

    logic                                clk = 1'b0;
    logic                                reset = 1'b1;
    memory_protection_pkg::reg_req_s     req = '0;
    logic [31:0]                         rdata;
    memory_protection_pkg::access_req_s  acc;
    memory_protection_pkg::access_resp_s resp;
    logic                                irq;
    int                                  failures = 0;
    int                                  n_tests = 0;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Checker under test and the pipeline in front of it.
    physical_memory_protection_unit dut (
        .clk_i         (clk),
        .reset_i       (reset),
        .reg_req_i     (req),
        .reg_rdata_o   (rdata),
        .access_req_i  (acc),
        .access_resp_o (resp),
        .irq_o         (irq)
    );
    pipeline_model pipe (
        .clk_i  (clk),
        .req_o  (acc),
        .resp_i (resp)
    );

    // ==========================================================================
    // Shared tasks.
    // Compares one value and reports a difference at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    // One-cycle read strobe; the data stand only in the following cycle.
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        req <= '0;
        #1;
        check(rdata, exp);
        @(posedge clk);
        #1;
        check(rdata, 32'h0);
    endtask

    // Issues one access and checks grant and the fault bit of its kind.
    task automatic acc_check(input memory_protection_pkg::access_kind_e k,
                             input memory_protection_pkg::priv_level_e p,
                             input logic [55:0] a, input logic g);
        memory_protection_pkg::access_resp_s r;
        logic [2:0] f;
        f = g ? 3'b000 : (3'b001 << k);
        pipe.issue(k, p, a, r);
        check({27'h0, r.valid, r.granted, r.fault}, {27'h0, 1'b1, g, f});
    endtask

    // Looks at the interrupt level once the last write has landed.
    task automatic irq_check(input logic exp);
        @(posedge clk);
        #1;
        check({31'h0, irq}, {31'h0, exp});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================================
    // Test sequence.
    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        read_check(8'h00, 32'h0);
        read_check(8'h60, 32'h0);
        irq_check(1'b0);
        acc_check(ld, usr, 56'h10, 1'b0);
        acc_check(st, mch, 56'h10, 1'b1);
        // Program three regions, regions 0 and 2 overlapping.
        reg_write(8'h20, 32'h0000_0100);
        reg_write(8'h24, 32'h1000_01ff);
        reg_write(8'h28, 32'h0000_00ff);
        reg_write(8'h00, 32'h001f_1c09);
        read_check(8'h00, 32'h001f_1c09);
        read_check(8'h24, 32'h1000_01ff);
        acc_check(ld, usr, 56'h3fc, 1'b1);
        acc_check(st, usr, 56'h3fc, 1'b0);
        acc_check(st, usr, 56'h3ff, 1'b0);
        acc_check(st, usr, 56'h400, 1'b1);
        acc_check(st, mch, 56'h10, 1'b1);
        acc_check(fe, usr, 56'h4000_0ffc, 1'b1);
        acc_check(fe, usr, 56'h4000_1000, 1'b0);
        acc_check(fe, usr, 56'h3fff_fffc, 1'b0);
        acc_check(ld, usr, 56'h4000_0000, 1'b0);
        read_check(8'h6c, 32'h4000_0000);
        // A single address write moves the power-of-two region.
        reg_write(8'h24, 32'h2000_00ff);
        acc_check(fe, usr, 56'h8000_07fc, 1'b1);
        acc_check(fe, usr, 56'h8000_0800, 1'b0);
        acc_check(fe, usr, 56'h4000_0000, 1'b0);
        // Sticky status, enable mask, clear and the interrupt level.
        read_check(8'h60, 32'h7);
        irq_check(1'b0);
        reg_write(8'h68, 32'h2);
        irq_check(1'b1);
        reg_write(8'h64, 32'h2);
        read_check(8'h60, 32'h5);
        irq_check(1'b0);
        reg_write(8'h68, 32'h5);
        irq_check(1'b1);
        reg_write(8'h68, 32'h0);
        irq_check(1'b0);
        reg_write(8'h64, 32'h7);
        read_check(8'h60, 32'h0);
        read_check(8'hf0, 32'h0);
        // Locking region 0 binds machine accesses and freezes its registers.
        reg_write(8'h00, 32'h001f_1c89);
        acc_check(st, mch, 56'h10, 1'b0);
        acc_check(ld, mch, 56'h10, 1'b1);
        reg_write(8'h00, 32'h001f_1c0f);
        reg_write(8'h20, 32'h0000_0200);
        read_check(8'h00, 32'h001f_1c89);
        read_check(8'h20, 32'h0000_0100);
        acc_check(st, mch, 56'h10, 1'b0);
        // Reserved configuration bits read as zero.
        reg_write(8'h04, 32'h0000_0067);
        read_check(8'h04, 32'h0000_0007);
        // Only a reset releases the lock.
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        read_check(8'h00, 32'h0);
        acc_check(st, mch, 56'h10, 1'b1);
        summarize;
    end

    // Watchdog against a hung handshake.
    initial
    begin
        #100000;
        failures++;
        summarize;
    end
endmodule // test_physical_memory_protection_unit

`default_nettype wire
